// ### verilog/uart_flags_pkg.sv
// Package for the serial port flag, divisor and queue block.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register bus.
package uart_flags_pkg;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_DATA     = 8'h00;
    localparam logic [7:0] OFS_FLAGS    = 8'h18;
    localparam logic [7:0] OFS_LOWPOWER = 8'h20;
    localparam logic [7:0] OFS_DIV_INT  = 8'h24;
    localparam logic [7:0] OFS_DIV_FRAC = 8'h28;
    localparam logic [7:0] OFS_LINECTL  = 8'h2C;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int BIT_CTS      = 0;
    localparam int BIT_BUSY     = 3;
    localparam int BIT_RX_EMPTY = 4;
    localparam int BIT_TX_FULL  = 5;
    localparam int BIT_RX_FULL  = 6;
    localparam int BIT_TX_EMPTY = 7;
    localparam int BIT_QMODE    = 4;
    localparam logic [15:0] RST_DIV_INT  = 16'h0000;
    localparam logic [5:0]  RST_DIV_FRAC = 6'h00;

    // ************************************************************
    // Queue sizes and bus answers
    // ************************************************************
    localparam int          QDEPTH    = 16;
    localparam logic [4:0]  QFULL_CNT = 5'h10;
    localparam logic [1:0]  SKID_FULL = 2'h2;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLV  = 2'h2;

    // Whole state of the block, registered as one word
    typedef struct packed {
        logic [QDEPTH-1:0][7:0] tx_mem;
        logic [3:0]             tx_rd;
        logic [3:0]             tx_wr;
        logic [4:0]             tx_cnt;
        logic [QDEPTH-1:0][7:0] rx_mem;
        logic [3:0]             rx_rd;
        logic [3:0]             rx_wr;
        logic [4:0]             rx_cnt;
        logic [1:0][7:0]        skid;
        logic [1:0]             skid_cnt;
        logic                   qmode;
        logic [15:0]            div_int;
        logic [5:0]             div_frac;
        logic [15:0]            act_int;
        logic [5:0]             act_frac;
        logic [16:0]            baud_cnt;
        logic [5:0]             acc;
        logic                   extra;
        logic                   tick;
        logic                   aw_got;
        logic [7:0]             aw_addr;
        logic                   w_got;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } state_s;

endpackage : uart_flags_pkg

// ### verilog/uart_flags_and_baud_divisor.sv
// Flag register, divisor registers, queues and oversampling tick of
// an asynchronous serial port, reached over AXI4-Lite.
// Assumes the shift logic outside drains TX_*, fills RX_* and reports
// its busy levels; all inputs are synchronous to CLK_I.
//
// Overview of operation
// - Transmit-empty: holding register empty, or queue empty in queued mode.
// - Transmit-empty flag ignores the shift register contents.
// - Receive-full flag: holding register full, or queue completely full.
// - Transmit-full flag: holding register full, or queue completely full.
// - Receive-empty flag: holding register empty, or queue empty.
// - Busy reads one until the whole character has left the shifter.
// - Busy rises once the transmit queue holds anything, enabled or not.
// - Clear-to-send status is the inverse of the active-low modem input.
// - Ring, carrier and data-set-ready positions unsupported; write zero.
// - Low-power dummy register ignores writes and reads zero.
// - Sixteen-bit integer divisor, read-write, resets to zero.
// - Six-bit fractional divisor, read-write, resets to zero.
// - Divisor equals reference clock over sixteen times the bit rate.
// - New divisor takes effect only after the current character ends.
// - Queue mode bit: clear gives one-entry holding registers, set queues.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module uart_flags_and_baud_divisor (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        SYS_RST_I,
    // AXI4-Lite write address and data
    input  wire logic        AWVALID_I,
    output logic             AWREADY_O,
    input  wire logic [7:0]  AWADDR_I,
    input  wire logic        WVALID_I,
    output logic             WREADY_O,
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  WSTRB_I,
    // AXI4-Lite write response
    output logic             BVALID_O,
    input  wire logic        BREADY_I,
    output logic [1:0]       BRESP_O,
    // AXI4-Lite read
    input  wire logic        ARVALID_I,
    output logic             ARREADY_O,
    input  wire logic [7:0]  ARADDR_I,
    output logic             RVALID_O,
    input  wire logic        RREADY_I,
    output logic [31:0]      RDATA_O,
    output logic [1:0]       RRESP_O,
    // Transmit characters toward the shift register
    output logic             TX_VALID_O,
    input  wire logic        TX_READY_I,
    output logic [7:0]       TX_DATA_O,
    input  wire logic        TX_SHIFT_BUSY_I,
    // Received characters from the shift register
    input  wire logic        RX_VALID_I,
    output logic             RX_READY_O,
    input  wire logic [7:0]  RX_DATA_I,
    input  wire logic        RX_BUSY_I,
    // Modem and timing
    input  wire logic        MODEM_CTS_N_I,
    output logic             QUEUE_MODE_O,
    output logic             BAUD16_TICK_O
);

    // ************************************************************
    // State and derived flags
    // ************************************************************
    uart_flags_pkg::state_s s;
    uart_flags_pkg::state_s next_s;
    logic        tx_empty;
    logic        tx_full;
    logic        rx_empty;
    logic        rx_full;
    logic        tx_busy;
    logic [31:0] flags;
    logic        aw_hs;
    logic        w_hs;
    logic        ar_hs;
    logic        tx_push;
    logic        rx_pop;
    logic        skid_pop;
    logic        skid_push;
    logic        do_write;
    logic [16:0] period;
    logic [6:0]  acc_sum;

    // Full flags depend on the mode: one entry or the full depth
    assign tx_empty = (s.tx_cnt == 5'h00);
    assign rx_empty = (s.rx_cnt == 5'h00);
    assign tx_full  = s.qmode ? (s.tx_cnt == uart_flags_pkg::QFULL_CNT)
                              : !tx_empty;
    assign rx_full  = s.qmode ? (s.rx_cnt == uart_flags_pkg::QFULL_CNT)
                              : !rx_empty;
    // Staged words count as being transmitted, not as queued
    assign tx_busy  = !tx_empty || (s.skid_cnt != 2'h0)
                      || TX_SHIFT_BUSY_I;

    // Flag word; unsupported modem positions read as zero
    always_comb begin
        flags = 32'h0000_0000;
        flags[uart_flags_pkg::BIT_TX_EMPTY] = tx_empty;
        flags[uart_flags_pkg::BIT_RX_FULL]  = rx_full;
        flags[uart_flags_pkg::BIT_TX_FULL]  = tx_full;
        flags[uart_flags_pkg::BIT_RX_EMPTY] = rx_empty;
        flags[uart_flags_pkg::BIT_BUSY]     = tx_busy;
        flags[uart_flags_pkg::BIT_CTS]      = !MODEM_CTS_N_I;
    end

    // ************************************************************
    // Handshakes
    // ************************************************************
    // One write in flight: address and data wait for the response
    assign AWREADY_O  = !s.aw_got && !s.bvalid;
    assign WREADY_O   = !s.w_got && !s.bvalid;
    assign ARREADY_O  = !s.rvalid;
    assign aw_hs      = AWVALID_I && AWREADY_O;
    assign w_hs       = WVALID_I && WREADY_O;
    assign ar_hs      = ARVALID_I && ARREADY_O;
    assign do_write   = s.aw_got && s.w_got;
    assign tx_push    = do_write && (s.aw_addr == uart_flags_pkg::OFS_DATA)
                        && s.w_strb[0] && !tx_full;
    assign rx_pop     = ar_hs && (ARADDR_I == uart_flags_pkg::OFS_DATA)
                        && !rx_empty;
    assign RX_READY_O = !rx_full;
    // Two-entry stage so a stalled shifter never drops a word
    assign TX_VALID_O = (s.skid_cnt != 2'h0);
    assign TX_DATA_O  = s.skid[0];
    assign skid_pop   = TX_VALID_O && TX_READY_I;
    assign skid_push  = !tx_empty && (s.skid_cnt != uart_flags_pkg::SKID_FULL);
    assign period     = {1'b0, s.act_int} + {16'h0000, s.extra};
    assign acc_sum    = {1'b0, s.acc} + {1'b0, s.act_frac};

    // Registered bus and status outputs
    assign BVALID_O      = s.bvalid;
    assign BRESP_O       = s.bresp;
    assign RVALID_O      = s.rvalid;
    assign RDATA_O       = s.rdata;
    assign RRESP_O       = s.rresp;
    assign QUEUE_MODE_O  = s.qmode;
    assign BAUD16_TICK_O = s.tick;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        next_s = s;

        // Write channel capture, either order
        if (aw_hs) begin
            next_s.aw_got  = 1'b1;
            next_s.aw_addr = AWADDR_I;
        end
        if (w_hs) begin
            next_s.w_got  = 1'b1;
            next_s.w_data = WDATA_I;
            next_s.w_strb = WSTRB_I;
        end
        if (s.bvalid && BREADY_I) begin
            next_s.bvalid = 1'b0;
        end

        // Register write; a full queue silently drops the character
        if (do_write) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = uart_flags_pkg::RESP_OKAY;
            if (s.aw_addr == uart_flags_pkg::OFS_DATA) begin
                if (tx_push) begin
                    next_s.tx_mem[s.tx_wr] = s.w_data[7:0];
                    next_s.tx_wr = s.tx_wr + 4'h1;
                end
            end else if (s.aw_addr == uart_flags_pkg::OFS_DIV_INT) begin
                if (s.w_strb[0]) begin
                    next_s.div_int[7:0] = s.w_data[7:0];
                end
                if (s.w_strb[1]) begin
                    next_s.div_int[15:8] = s.w_data[15:8];
                end
            end else if (s.aw_addr == uart_flags_pkg::OFS_DIV_FRAC) begin
                if (s.w_strb[0]) begin
                    next_s.div_frac = s.w_data[5:0];
                end
            end else if (s.aw_addr == uart_flags_pkg::OFS_LINECTL) begin
                if (s.w_strb[0]) begin
                    next_s.qmode = s.w_data[uart_flags_pkg::BIT_QMODE];
                end
            end else if (s.aw_addr == uart_flags_pkg::OFS_FLAGS) begin
                next_s.bresp = uart_flags_pkg::RESP_OKAY;
            end else if (s.aw_addr == uart_flags_pkg::OFS_LOWPOWER) begin
                next_s.bresp = uart_flags_pkg::RESP_OKAY;
            end else begin
                next_s.bresp = uart_flags_pkg::RESP_SLV;
            end
        end

        // Read channel; data is sampled at the address handshake
        if (s.rvalid && RREADY_I) begin
            next_s.rvalid = 1'b0;
        end
        if (ar_hs) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = uart_flags_pkg::RESP_OKAY;
            next_s.rdata  = 32'h0000_0000;
            if (ARADDR_I == uart_flags_pkg::OFS_DATA) begin
                if (!rx_empty) begin
                    next_s.rdata[7:0] = s.rx_mem[s.rx_rd];
                end
            end else if (ARADDR_I == uart_flags_pkg::OFS_FLAGS) begin
                next_s.rdata = flags;
            end else if (ARADDR_I == uart_flags_pkg::OFS_LOWPOWER) begin
                next_s.rdata = 32'h0000_0000;
            end else if (ARADDR_I == uart_flags_pkg::OFS_DIV_INT) begin
                next_s.rdata[15:0] = s.div_int;
            end else if (ARADDR_I == uart_flags_pkg::OFS_DIV_FRAC) begin
                next_s.rdata[5:0] = s.div_frac;
            end else if (ARADDR_I == uart_flags_pkg::OFS_LINECTL) begin
                next_s.rdata[uart_flags_pkg::BIT_QMODE] = s.qmode;
            end else begin
                next_s.rresp = uart_flags_pkg::RESP_SLV;
            end
        end

        // Receive queue fill and drain
        if (rx_pop) begin
            next_s.rx_rd = s.rx_rd + 4'h1;
        end
        if (RX_VALID_I && RX_READY_O) begin
            next_s.rx_mem[s.rx_wr] = RX_DATA_I;
            next_s.rx_wr = s.rx_wr + 4'h1;
        end
        next_s.rx_cnt = s.rx_cnt + {4'h0, RX_VALID_I && RX_READY_O}
                        - {4'h0, rx_pop};

        // Transmit queue into the two-entry stage
        if (skid_push) begin
            next_s.tx_rd = s.tx_rd + 4'h1;
        end
        next_s.tx_cnt = s.tx_cnt + {4'h0, tx_push} - {4'h0, skid_push};
        if (skid_pop) begin
            next_s.skid[0] = s.skid[1];
        end
        if (skid_push) begin
            if (s.skid_cnt == 2'h0 || (s.skid_cnt == 2'h1 && skid_pop)) begin
                next_s.skid[0] = s.tx_mem[s.tx_rd];
            end else begin
                next_s.skid[1] = s.tx_mem[s.tx_rd];
            end
        end
        next_s.skid_cnt = s.skid_cnt + {1'b0, skid_push}
                          - {1'b0, skid_pop};

        // Changing the mode flushes both queues
        if (do_write && s.aw_addr == uart_flags_pkg::OFS_LINECTL
            && s.w_strb[0]
            && s.w_data[uart_flags_pkg::BIT_QMODE] != s.qmode) begin
            next_s.tx_rd  = 4'h0;
            next_s.tx_wr  = 4'h0;
            next_s.tx_cnt = 5'h00;
            next_s.rx_rd  = 4'h0;
            next_s.rx_wr  = 4'h0;
            next_s.rx_cnt = 5'h00;
        end

        // Divisor moves into use only between characters
        if (!TX_SHIFT_BUSY_I && !RX_BUSY_I) begin
            next_s.act_int  = s.div_int;
            next_s.act_frac = s.div_frac;
        end

        // Sixteen-times tick; a zero divisor stops it
        next_s.tick = 1'b0;
        if (s.act_int == 16'h0000) begin
            next_s.baud_cnt = 17'h00001;
        end else if (s.baud_cnt >= period) begin
            next_s.tick     = 1'b1;
            next_s.baud_cnt = 17'h00001;
            next_s.acc      = acc_sum[5:0];
            next_s.extra    = acc_sum[6];
        end else begin
            next_s.baud_cnt = s.baud_cnt + 17'h00001;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Empty queues: both empty flags set, full flags clear; busy and clear-to-send follow their inputs
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            s          <= '0;
            s.div_int  <= uart_flags_pkg::RST_DIV_INT;
            s.div_frac <= uart_flags_pkg::RST_DIV_FRAC;
            s.baud_cnt <= 17'h00001;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    // Flag read returns the empty state seen at the handshake
    a_tx_empty_read: assert property (
        ar_hs && ARADDR_I == uart_flags_pkg::OFS_FLAGS
        |=> s.rdata[7] == $past(s.tx_cnt == 5'h00))
        else $error("transmit-empty flag read wrong");

    a_empty_ignores_shift: assert property (
        TX_SHIFT_BUSY_I && s.tx_cnt == 5'h00 |-> flags[7] && flags[3])
        else $error("transmit-empty tied to shift state");

    a_rx_full_flag: assert property (
        flags[6] == (s.qmode ? s.rx_cnt == 5'h10 : s.rx_cnt != 5'h00))
        else $error("receive-full flag wrong");

    a_tx_full_flag: assert property (
        flags[5] == (s.qmode ? s.tx_cnt == 5'h10 : s.tx_cnt != 5'h00))
        else $error("transmit-full flag wrong");

    a_rx_empty_pop: assert property (
        s.rx_cnt == 5'h01 && rx_pop && !(RX_VALID_I && RX_READY_O)
        |=> flags[4])
        else $error("receive-empty not set after last pop");

    a_busy_while_shift: assert property (
        TX_SHIFT_BUSY_I || TX_VALID_O |-> flags[3])
        else $error("busy dropped during transmission");

    a_busy_on_push: assert property (
        tx_push |=> flags[3] [*2])
        else $error("busy not raised by queued character");

    a_cts_inverse: assert property (
        ar_hs && ARADDR_I == uart_flags_pkg::OFS_FLAGS
        |=> s.rdata[0] == !$past(MODEM_CTS_N_I))
        else $error("clear-to-send not inverted");

    a_lowpower_zero: assert property (
        ar_hs && ARADDR_I == uart_flags_pkg::OFS_LOWPOWER
        |=> s.rdata == 32'h0000_0000 && s.rresp == 2'h0)
        else $error("low-power register not zero");

    a_divisor_held: assert property (
        TX_SHIFT_BUSY_I || RX_BUSY_I |=> $stable(s.act_int)
        && $stable(s.act_frac))
        else $error("divisor changed mid character");

    a_tick_spacing: assert property (
        s.tick && s.act_int > 16'h0001 && $stable(s.act_int) |=> !s.tick)
        else $error("tick period too short");

    a_tick_stop: assert property (
        s.act_int == 16'h0000 |=> !s.tick)
        else $error("tick with zero divisor");

endmodule : uart_flags_and_baud_divisor

// ### testbench/far_end_model.sv
// Behavioural far end: a shifter that takes transmit words and a
// receiver that offers characters. Shares the block's clock and reset.
`timescale 1ns/100ps
module far_end_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Transmit side
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       stall_i,
    output logic            tx_ready_o,
    output logic            shift_busy_o,
    // Receive side
    input  wire logic       rx_go_i,
    input  wire logic [7:0] rx_char_i,
    input  wire logic       rx_ready_i,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o
);
    logic [5:0] left;
    logic [7:0] held;
    logic [7:0] last;
    // Busy only while a character is on the line
    assign shift_busy_o = (left != 6'h00);
    assign tx_ready_o   = !stall_i && !shift_busy_o;
    // Released data shows the inverse, so stale values never match
    assign rx_data_o    = rx_valid_o ? held : ~last;
    // Shifter countdown and receive offer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            left       <= 6'h00;
            held       <= 8'h00;
            last       <= 8'h00;
            rx_valid_o <= 1'b0;
        end else begin
            if (tx_valid_i && tx_ready_o) left <= 6'h14;
            else if (shift_busy_o) left <= left - 6'h01;
            if (rx_go_i) begin
                held       <= rx_char_i;
                rx_valid_o <= 1'b1;
            end else if (rx_valid_o && rx_ready_i) begin
                last       <= held;
                rx_valid_o <= 1'b0;
            end
        end
    end
endmodule : far_end_model

// ### testbench/uart_flags_and_baud_divisor_tb.sv
// Self-checking bench for the flag, divisor and queue block.
// Assumes the far end model drives the shifter and receiver pins.
`timescale 1ns/100ps
module uart_flags_and_baud_divisor_tb;
    localparam logic [7:0] A_DAT = uart_flags_pkg::OFS_DATA;
    localparam logic [7:0] A_FL  = uart_flags_pkg::OFS_FLAGS;
    localparam logic [7:0] A_LP  = uart_flags_pkg::OFS_LOWPOWER;
    localparam logic [7:0] A_DI  = uart_flags_pkg::OFS_DIV_INT;
    localparam logic [7:0] A_DF  = uart_flags_pkg::OFS_DIV_FRAC;
    localparam logic [7:0] A_LC  = uart_flags_pkg::OFS_LINECTL;
    logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, rvalid, cts_n, qmode, tick;
    logic        tx_valid, tx_ready, shift_busy, rx_valid, rx_ready;
    logic        rx_hold, stall, rx_go;
    logic [7:0]  awaddr, araddr, tx_data, rx_data, rx_char;
    logic [31:0] wdata, rdata, r;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic [7:0]  sent_q[$];
    logic [7:0]  seen_q[$];
    int          n_mismatch, total_checks, cnt;

    // ************************************************************
    // Design and far end
    // ************************************************************
    uart_flags_and_baud_divisor u_dut (
        .CLK_I(clk), .SYS_RST_I(rst), .AWVALID_I(awvalid),
        .AWREADY_O(awready), .AWADDR_I(awaddr), .WVALID_I(wvalid),
        .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(wstrb),
        .BVALID_O(bvalid), .BREADY_I(bready), .BRESP_O(bresp),
        .ARVALID_I(arvalid), .ARREADY_O(), .ARADDR_I(araddr),
        .RVALID_O(rvalid), .RREADY_I(rready), .RDATA_O(rdata),
        .RRESP_O(rresp), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready),
        .TX_DATA_O(tx_data), .TX_SHIFT_BUSY_I(shift_busy),
        .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready), .RX_DATA_I(rx_data),
        .RX_BUSY_I(rx_hold), .MODEM_CTS_N_I(cts_n), .QUEUE_MODE_O(qmode),
        .BAUD16_TICK_O(tick));
    far_end_model u_far (
        .clk_i(clk), .rst_i(rst), .tx_valid_i(tx_valid),
        .tx_data_i(tx_data), .stall_i(stall), .tx_ready_o(tx_ready),
        .shift_busy_o(shift_busy), .rx_go_i(rx_go), .rx_char_i(rx_char),
        .rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data));

    // Record every word the shifter takes
    always @(posedge clk) if (tx_valid && tx_ready) seen_q.push_back(tx_data);

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic tmo();
        n_mismatch++;
        $display("unexpected at %0t: wait ran out", $time);
        close_out();
    endtask : tmo
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    // Ready lines stay high throughout, so no same-step re-raise occurs
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (n > 50) tmo();
        end while (!bvalid);
        resp = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && u_dut.ARREADY_O) arvalid <= 1'b0;
            if (n > 50) tmo();
        end while (!rvalid);
        r    = rdata;
        resp = rresp;
    endtask : rd
    task automatic wdc(input logic [7:0] c);
        wr(A_DAT, {24'h000000, c});
        sent_q.push_back(c);
    endtask : wdc
    // Wait for idle, then compare what reached the line, in order
    task automatic drain();
        int n;
        for (n = 0; n < 100; n++) begin
            rd(A_FL);
            if (r[3] === 1'b0) break;
            wt(10);
        end
        if (n == 100) tmo();
        chk(r & 32'h000000A8, 32'h00000080);
        chk(seen_q.size(), sent_q.size());
        while (sent_q.size() > 0) chk(seen_q.pop_front(), sent_q.pop_front());
    endtask : drain
    task automatic push(input logic [7:0] c);
        int n;
        n = 0;
        rx_char <= c;
        rx_go   <= 1'b1;
        @(posedge clk);
        rx_go <= 1'b0;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) tmo();
        end while (rx_valid);
    endtask : push
    task automatic span(input int k, output int c);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!tick && n < 300);
        c = 0;
        while (k > 0 && c < 1000) begin
            @(posedge clk);
            c++;
            if (tick) k--;
        end
        if (n >= 300 || c >= 1000) tmo();
    endtask : span

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic s_reset();
        rd(A_FL);
        chk(r, 32'h00000090);
        cts_n <= 1'b0;
        wt(2);
        rd(A_FL);
        chk(r, 32'h00000091);
        cts_n <= 1'b1;
    endtask : s_reset
    task automatic s_regs();
        rd(A_DI);
        chk(r, 32'h00000000);
        rd(A_DF);
        chk(r, 32'h00000000);
        wr(A_DI, 32'hFFFFFFFF);
        rd(A_DI);
        chk(r, 32'h0000FFFF);
        wr(A_DF, 32'hFFFFFFFF);
        rd(A_DF);
        chk(r, 32'h0000003F);
        wr(A_LP, 32'hFFFFFFFF);
        chk(resp, uart_flags_pkg::RESP_OKAY);
        rd(A_LP);
        chk(r, 32'h00000000);
        rd(8'h3C);
        chk(resp, uart_flags_pkg::RESP_SLV);
    endtask : s_regs
    task automatic s_txchar();
        stall <= 1'b1;
        wdc(8'hA1);
        wt(4);
        rd(A_FL);
        chk(r & 32'h000000A8, 32'h00000088);
        wdc(8'hA2);
        wdc(8'hA3);
        wt(4);
        rd(A_FL);
        chk(r & 32'h000000A8, 32'h00000028);
        stall <= 1'b0;
        wt(4);
        rd(A_FL);
        chk(r & 32'h00000088, 32'h00000088);
        drain();
    endtask : s_txchar
    task automatic s_txq();
        wr(A_LC, 32'h00000010);
        chk(qmode, 1'b1);
        stall <= 1'b1;
        for (int i = 0; i < 17; i++) wdc(i[7:0]);
        wt(4);
        rd(A_FL);
        chk(r & 32'h00000020, 32'h00000000);
        wdc(8'h55);
        wt(4);
        rd(A_FL);
        chk(r & 32'h000000A8, 32'h00000028);
        wr(A_DAT, 32'h00000066);
        chk(resp, uart_flags_pkg::RESP_OKAY);
        stall <= 1'b0;
        drain();
    endtask : s_txq
    task automatic s_rx();
        for (int i = 0; i < 16; i++) push(8'hC0 + i[7:0]);
        rd(A_FL);
        chk(r & 32'h00000050, 32'h00000040);
        chk(rx_ready, 1'b0);
        for (int i = 0; i < 16; i++) begin
            rd(A_DAT);
            chk(r, 32'h000000C0 + i);
        end
        rd(A_FL);
        chk(r & 32'h00000050, 32'h00000010);
        wr(A_LC, 32'h00000000);
        push(8'h5A);
        rd(A_FL);
        chk(r & 32'h00000050, 32'h00000040);
        rd(A_DAT);
        chk(r, 32'h0000005A);
    endtask : s_rx
    task automatic s_tick();
        wr(A_DF, 32'h00000000);
        wr(A_DI, 32'h00000004);
        span(1, cnt);
        chk(cnt, 32'h00000004);
        wr(A_DF, 32'h00000020);
        wt(1); // Let the last old-fraction tick pass
        span(8, cnt);
        chk(cnt, 32'h00000024);
        rx_hold <= 1'b1;
        wr(A_DI, 32'h00000006);
        wt(20);
        span(8, cnt);
        chk(cnt, 32'h00000024);
        rx_hold <= 1'b0;
        wt(20);
        span(8, cnt);
        chk(cnt, 32'h00000034);
    endtask : s_tick

    // ************************************************************
    // Clock and main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Reset for 20 cycles, then every scenario in turn
    initial begin
        rst = 1'b1;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        bready = 1'b1;
        rready = 1'b1;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        cts_n = 1'b1;
        stall = 1'b0;
        rx_go = 1'b0;
        rx_char = 8'h00;
        rx_hold = 1'b0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s_reset();
        s_regs();
        s_txchar();
        s_txq();
        s_rx();
        s_tick();
        close_out();
    end
endmodule : uart_flags_and_baud_divisor_tb
